// ---- hw/jtx_pkg.sv ----
package jtx_pkg;
  // Bus and stream widths
  localparam int JTX_HDW = 32;
  localparam int JTX_SW  = 16;
  localparam logic [2:0] JTX_HSIZE_WORD = 3'h2;
  // Register indices, byte address is four times the index
  localparam logic [3:0] JTX_IDX_LINK = 4'h0;
  localparam logic [3:0] JTX_IDX_LANE = 4'h1;
  localparam logic [3:0] JTX_IDX_PAT  = 4'h2;
  localparam logic [3:0] JTX_IDX_KLEN = 4'h6;
  localparam logic [3:0] JTX_IDX_STAT = 4'h8;
  // Writable bits and reset values
  localparam logic [7:0] JTX_MSK_LINK = 8'h9F;
  localparam logic [7:0] JTX_MSK_PAT  = 8'hF8;
  localparam logic [7:0] JTX_MSK_KLEN = 8'h1F;
  localparam logic [7:0] JTX_RST_LINK = 8'h00;
  localparam logic [7:0] JTX_RST_LANE = 8'h01;
  localparam logic [7:0] JTX_RST_PAT  = 8'h00;
  localparam logic [7:0] JTX_RST_KLEN = 8'h08;
  // link_control fields
  localparam int JTX_B_CTRL_K   = 7;
  localparam int JTX_B_TPL      = 4;
  localparam int JTX_B_FLIP     = 3;
  localparam int JTX_B_LANE_AL  = 2;
  localparam int JTX_B_FRAME_AL = 1;
  localparam int JTX_B_ILA_SUP  = 0;
  // lane_and_sync_config fields
  localparam int JTX_B_SYNC_REG = 7;
  localparam int JTX_B_SYNC_SEL = 6;
  localparam int JTX_DEC_LSB    = 3;
  localparam int JTX_MODE_LSB   = 0;
  // link_test_pattern_config fields
  localparam int JTX_PAT_LSB    = 5;
  localparam int JTX_B_MF_MASK  = 3;
  // Link pattern codes
  localparam logic [2:0] JTX_PAT_NORM    = 3'h0;
  localparam logic [2:0] JTX_PAT_D215    = 3'h1;
  localparam logic [2:0] JTX_PAT_K285    = 3'h2;
  localparam logic [2:0] JTX_PAT_REP_ILA = 3'h3;
  localparam logic [2:0] JTX_PAT_RPAT    = 3'h4;
  // Multiframe and alignment sequence counts
  localparam logic [4:0] JTX_KMAX_DEF   = 5'h04;
  localparam logic [1:0] JTX_ILA_LAST   = 2'h3;
  localparam logic [1:0] JTX_ILA_CFG_MF = 2'h1;
  localparam logic [2:0] JTX_RPAT_LAST  = 3'h5;
  // Control and data characters
  localparam logic [7:0] JTX_K28_0 = 8'h1C;
  localparam logic [7:0] JTX_K28_3 = 8'h7C;
  localparam logic [7:0] JTX_K28_4 = 8'h9C;
  localparam logic [7:0] JTX_K28_5 = 8'hBC;
  localparam logic [7:0] JTX_K28_7 = 8'hFC;
  localparam logic [7:0] JTX_D21_5 = 8'hB5;
  localparam logic [15:0] JTX_RPAT [6] = '{16'hBED7, 16'h2347, 16'h6B8F,
                                           16'hB314, 16'h5EFB, 16'h3559};
  typedef enum logic [1:0] {JTX_LS_SYNC, JTX_LS_WAIT, JTX_LS_ILA, JTX_LS_DATA} jtx_link_st_t;

  // Active lane mask for a decimation and lane count pair
  function automatic logic [7:0] jtx_lane_mask(input logic [2:0] dec, input logic [2:0] mode);
    unique case ({dec, mode})
      6'o01:                      jtx_lane_mask = 8'hFF;
      6'o02, 6'o04, 6'o71, 6'o61: jtx_lane_mask = 8'h0F;
      6'o62, 6'o41, 6'o72:        jtx_lane_mask = 8'h03;
      6'o42:                      jtx_lane_mask = 8'h01;
      default:                    jtx_lane_mask = 8'h00;
    endcase
  endfunction

  // Bit order reversal of one sample word
  function automatic logic [15:0] jtx_rev16(input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      jtx_rev16[i] = w[15-i];
    end
  endfunction
endpackage

// ---- hw/jtx_tpl_gen.sv ----
`timescale 1ns/1ps
module jtx_tpl_gen (
  // Clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_n_i,
  // Multiframe boundary
  input  wire logic                       mf_end_i,
  // Test sample word
  output logic [jtx_pkg::JTX_SW-1:0]      word_o
);
  import jtx_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
  } jtx_tpl_st_t;

  jtx_tpl_st_t st_r;
  jtx_tpl_st_t st_nxt;

  // Sample index restarts at every multiframe
  always_comb begin
    st_nxt     = st_r;
    st_nxt.cnt = mf_end_i ? 8'h00 : st_r.cnt + 8'h01;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Index in the high octet, its complement in the low octet
  assign word_o = {st_r.cnt, ~st_r.cnt};

  property p_tpl_restart;
    @(posedge sys_clk_i) disable iff (!rst_n_i) mf_end_i |=> word_o == 16'h00FF;
  endproperty
  a_tpl_restart: assert property (p_tpl_restart) else $error("test pattern did not restart");

  property p_tpl_step;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !mf_end_i |=> word_o[15:8] == $past(word_o[15:8]) + 8'h01;
  endproperty
  a_tpl_step: assert property (p_tpl_step) else $error("test pattern did not advance");
endmodule

// ---- hw/jtx_char_align.sv ----
`timescale 1ns/1ps
module jtx_char_align (
  // Clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_n_i,
  // Octet pair in, high octet first
  input  wire logic [jtx_pkg::JTX_SW-1:0] data_i,
  input  wire logic [1:0]                 k_i,
  input  wire logic                       en_i,
  input  wire logic                       mf_end_i,
  input  wire logic                       lane_al_i,
  input  wire logic                       frame_al_i,
  // Octet pair out
  output logic [jtx_pkg::JTX_SW-1:0]      data_o,
  output logic [1:0]                      k_o
);
  import jtx_pkg::*;

  typedef struct packed {
    logic [7:0]  prev;
    logic [15:0] data;
    logic [1:0]  k;
  } jtx_algn_st_t;

  jtx_algn_st_t st_r;
  jtx_algn_st_t st_nxt;
  logic         rep;

  // Frame end octet equal to the last one may be swapped for a marker
  always_comb begin
    st_nxt      = st_r;
    st_nxt.data = data_i;
    st_nxt.k    = k_i;
    st_nxt.prev = data_i[7:0];
    rep         = en_i && !k_i[0] && (data_i[7:0] == st_r.prev);
    if (rep && mf_end_i && lane_al_i) begin
      st_nxt.data[7:0] = JTX_K28_3;
      st_nxt.k[0]      = 1'b1;
    end else if (rep && !mf_end_i && frame_al_i) begin
      st_nxt.data[7:0] = JTX_K28_7;
      st_nxt.k[0]      = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign data_o = st_r.data;
  assign k_o    = st_r.k;

  property p_lane_mark;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      rep && mf_end_i && lane_al_i |=> k_o[0] && data_o[7:0] == 8'h7C;
  endproperty
  a_lane_mark: assert property (p_lane_mark) else $error("lane marker missing");

  property p_frame_mark;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      rep && !mf_end_i && frame_al_i |=> k_o[0] && data_o[7:0] == 8'hFC;
  endproperty
  a_frame_mark: assert property (p_frame_mark) else $error("frame marker missing");
endmodule

// ---- hw/jtx_link_ctrl.sv ----
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Control bit clear gives five frames per multiframe; set uses the length register.
// - Transport test enable replaces samples with the long transport test pattern.
// - Reversal bit emits every output sample word with bit order reversed.
// - Lane alignment enable swaps a data multiframe end octet that repeats the last one for K28.3.
// - Frame alignment enable swaps a data frame end octet that repeats the last one for K28.7.
// - Suppress bit skips the initial lane alignment sequence after sync release.
// - Sync source bit picks the pin or the register sync request.
// - Register sync request with register sourcing sends K28.5 instead of data.
// - Lane count select resets to 001, eight lanes; software matches the PLL.
// - No decimation: code 001 gives eight lanes, 010 or 100 four.
// - Code 001: 2X and 4X complex four lanes, 4X real two; 010 halves.
// - Link pattern select picks data, D21.5, K28.5, repeated ILA or RPAT.
// - Multiframe clock reset mask makes the block ignore reset requests.
module jtx_link_ctrl (
  // Clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_n_i,
  // AHB-Lite slave
  input  wire logic                        hsel_i,
  input  wire logic [jtx_pkg::JTX_HDW-1:0] haddr_i,
  input  wire logic [1:0]                  htrans_i,
  input  wire logic                        hwrite_i,
  input  wire logic [2:0]                  hsize_i,
  input  wire logic [jtx_pkg::JTX_HDW-1:0] hwdata_i,
  input  wire logic                        hready_i,
  output logic [jtx_pkg::JTX_HDW-1:0]      hrdata_o,
  output logic                             hreadyout_o,
  output logic                             hresp_o,
  // Link control inputs
  input  wire logic                        sync_n_i,
  input  wire logic                        mf_clk_rst_i,
  input  wire logic [jtx_pkg::JTX_SW-1:0]  sample_i,
  // Link stream and lane enables
  output logic [jtx_pkg::JTX_SW-1:0]       tx_data_o,
  output logic [1:0]                       tx_k_o,
  output logic [7:0]                       lane_en_o,
  output logic                             ila_active_o
);
  import jtx_pkg::*;

  typedef struct packed {
    logic [7:0]   link;
    logic [7:0]   lane;
    logic [7:0]   pat;
    logic [7:0]   klen;
    logic         ap_wr;
    logic         ap_ok;
    logic [3:0]   ap_idx;
    logic [31:0]  rdata;
    jtx_link_st_t st;
    logic [4:0]   fcnt;
    logic [1:0]   mcnt;
    logic [2:0]   rcnt;
    logic [7:0]   lane_en;
  } jtx_main_st_t;

  localparam jtx_main_st_t JTX_MAIN_RST = '{
    link:    JTX_RST_LINK,
    lane:    JTX_RST_LANE,
    pat:     JTX_RST_PAT,
    klen:    JTX_RST_KLEN,
    ap_wr:   1'b0,
    ap_ok:   1'b0,
    ap_idx:  4'h0,
    rdata:   32'h00000000,
    st:      JTX_LS_SYNC,
    fcnt:    5'h00,
    mcnt:    2'h0,
    rcnt:    3'h0,
    lane_en: 8'h00
  };

  jtx_main_st_t st_r;
  jtx_main_st_t st_nxt;
  logic [15:0]  tpl_word;
  logic [15:0]  samp_w;
  logic [15:0]  strm_data;
  logic [1:0]   strm_k;
  logic [4:0]   kmax;
  logic [2:0]   pat_sel;
  logic         sync_req;
  logic         mf_hit;
  logic         mf_end;
  logic         mf_wrap;
  logic         pat_test;
  logic         algn_en;
  logic         aph;

  // Sync source, multiframe length and boundary
  assign sync_req = st_r.lane[JTX_B_SYNC_SEL] ? st_r.lane[JTX_B_SYNC_REG] : !sync_n_i;
  assign mf_hit   = mf_clk_rst_i && !st_r.pat[JTX_B_MF_MASK];
  assign kmax     = st_r.link[JTX_B_CTRL_K] ? st_r.klen[4:0] : JTX_KMAX_DEF;
  assign mf_end   = (st_r.fcnt >= kmax); // A K cut below the count ends the multiframe at once
  assign mf_wrap  = mf_hit || mf_end;
  assign pat_sel  = st_r.pat[JTX_PAT_LSB +: 3];
  assign pat_test = pat_sel inside {JTX_PAT_D215, JTX_PAT_K285, JTX_PAT_RPAT};
  assign algn_en  = (st_r.st == JTX_LS_DATA) && !pat_test;
  assign aph      = hsel_i && htrans_i[1] && hready_i;

  // Register file, bus phases and link sequencing
  always_comb begin
    logic [3:0]  idx;
    logic [7:0]  wb;
    logic [31:0] rd;
    logic        ok;
    idx    = haddr_i[5:2];
    wb     = hwdata_i[7:0];
    rd     = 32'h00000000;
    ok     = (haddr_i[31:6] == 26'h0000000) && (haddr_i[1:0] == 2'b00) &&
             (hsize_i == JTX_HSIZE_WORD) &&
             (idx inside {JTX_IDX_LINK, JTX_IDX_LANE, JTX_IDX_PAT, JTX_IDX_KLEN, JTX_IDX_STAT});
    st_nxt = st_r;
    // Write data phase lands in the addressed register
    if (st_r.ap_wr && st_r.ap_ok) begin
      unique case (st_r.ap_idx)
        JTX_IDX_LINK: st_nxt.link = wb & JTX_MSK_LINK;
        JTX_IDX_LANE: st_nxt.lane = wb;
        JTX_IDX_PAT:  st_nxt.pat  = wb & JTX_MSK_PAT;
        JTX_IDX_KLEN: st_nxt.klen = wb & JTX_MSK_KLEN;
        default: ;
      endcase
    end
    // Address phase; read value includes a write landing now
    st_nxt.ap_wr = 1'b0;
    st_nxt.ap_ok = 1'b0;
    if (aph) begin
      st_nxt.ap_wr  = hwrite_i;
      st_nxt.ap_ok  = ok;
      st_nxt.ap_idx = idx;
      unique case (idx)
        JTX_IDX_LINK: rd[7:0] = st_nxt.link;
        JTX_IDX_LANE: rd[7:0] = st_nxt.lane;
        JTX_IDX_PAT:  rd[7:0] = st_nxt.pat;
        JTX_IDX_KLEN: rd[7:0] = st_nxt.klen;
        JTX_IDX_STAT: rd[14:0] = {st_r.fcnt, st_r.st, st_r.lane_en};
        default: ;
      endcase
      if (!hwrite_i) begin
        st_nxt.rdata = ok ? rd : 32'h00000000;
      end
    end
    // Frame counter; an unmasked reset request restarts it
    st_nxt.fcnt = mf_wrap ? 5'h00 : st_r.fcnt + 5'h01;
    // Link sequencing
    unique case (st_r.st)
      JTX_LS_SYNC: begin
        if (!sync_req) begin
          st_nxt.st = JTX_LS_WAIT;
        end
      end
      JTX_LS_WAIT: begin
        st_nxt.mcnt = 2'h0;
        if (mf_end) begin
          st_nxt.st = st_r.link[JTX_B_ILA_SUP] ? JTX_LS_DATA : JTX_LS_ILA;
        end
      end
      JTX_LS_ILA: begin
        if (mf_end) begin
          st_nxt.mcnt = st_r.mcnt + 2'h1;
          if (st_r.mcnt == JTX_ILA_LAST && pat_sel != JTX_PAT_REP_ILA) begin
            st_nxt.st = JTX_LS_DATA;
          end
        end
      end
      JTX_LS_DATA: begin
        st_nxt.mcnt = 2'h0;
        if (mf_end && pat_sel == JTX_PAT_REP_ILA) begin
          st_nxt.st = JTX_LS_ILA;
        end
      end
    endcase
    if (sync_req) begin
      st_nxt.st = JTX_LS_SYNC;
    end
    // RPAT word index
    st_nxt.rcnt = 3'h0;
    if (st_r.st == JTX_LS_DATA && pat_sel == JTX_PAT_RPAT && st_r.rcnt != JTX_RPAT_LAST) begin
      st_nxt.rcnt = st_r.rcnt + 3'h1;
    end
    st_nxt.lane_en = jtx_lane_mask(st_r.lane[JTX_DEC_LSB +: 3], st_r.lane[JTX_MODE_LSB +: 3]);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= JTX_MAIN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Sample source and bit order
  always_comb begin
    samp_w = st_r.link[JTX_B_TPL] ? tpl_word : sample_i;
    if (st_r.link[JTX_B_FLIP]) begin
      samp_w = jtx_rev16(samp_w);
    end
  end

  // Octet stream by link state and pattern
  always_comb begin
    strm_data = samp_w;
    strm_k    = 2'b00;
    unique case (st_r.st)
      JTX_LS_SYNC, JTX_LS_WAIT: begin
        strm_data = {JTX_K28_5, JTX_K28_5};
        strm_k    = 2'b11;
      end
      JTX_LS_ILA: begin
        strm_data = 16'h0000;
        if (st_r.fcnt == 5'h00) begin
          strm_data[15:8] = JTX_K28_0;
          strm_k[1]       = 1'b1;
          if (st_r.mcnt == JTX_ILA_CFG_MF) begin
            strm_data[7:0] = JTX_K28_4;
            strm_k[0]      = 1'b1;
          end
        end
        if (mf_end) begin
          strm_data[7:0] = JTX_K28_3;
          strm_k[0]      = 1'b1;
        end
      end
      JTX_LS_DATA: begin
        unique case (pat_sel)
          JTX_PAT_D215: strm_data = {JTX_D21_5, JTX_D21_5};
          JTX_PAT_K285: begin
            strm_data = {JTX_K28_5, JTX_K28_5};
            strm_k    = 2'b11;
          end
          JTX_PAT_RPAT: strm_data = JTX_RPAT[st_r.rcnt];
          default: strm_data = samp_w;
        endcase
      end
    endcase
  end

  jtx_tpl_gen u_tpl (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .mf_end_i  (mf_wrap),
    .word_o    (tpl_word)
  );

  jtx_char_align u_algn (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .data_i     (strm_data),
    .k_i        (strm_k),
    .en_i       (algn_en),
    .mf_end_i   (mf_end),
    .lane_al_i  (st_r.link[JTX_B_LANE_AL]),
    .frame_al_i (st_r.link[JTX_B_FRAME_AL]),
    .data_o     (tx_data_o),
    .k_o        (tx_k_o)
  );

  // Bus answers and status outputs
  assign hrdata_o     = st_r.rdata;
  assign hreadyout_o  = 1'b1;
  assign hresp_o      = 1'b0;
  assign lane_en_o    = st_r.lane_en;
  assign ila_active_o = (st_r.st == JTX_LS_ILA);

  sequence s_quiet_mf;
    (st_r.fcnt == 5'h00 && !st_r.link[JTX_B_CTRL_K] && !mf_hit)
      ##1 (!st_r.link[JTX_B_CTRL_K] && !mf_hit) [*4];
  endsequence

  property p_mf_default;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_quiet_mf |-> st_r.fcnt == 5'h04 && mf_end;
  endproperty
  a_mf_default: assert property (p_mf_default) else $error("default multiframe not five");

  property p_mf_prog;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      st_r.link[JTX_B_CTRL_K] && st_r.fcnt == st_r.klen[4:0] |=> st_r.fcnt == 5'h00;
  endproperty
  a_mf_prog: assert property (p_mf_prog) else $error("programmed multiframe length ignored");

  property p_mf_mask;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      mf_clk_rst_i && st_r.pat[JTX_B_MF_MASK] && !mf_end |=> st_r.fcnt == $past(st_r.fcnt) + 5'h01;
  endproperty
  a_mf_mask: assert property (p_mf_mask) else $error("masked reset request honoured");

  property p_mf_hit;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      mf_clk_rst_i && !st_r.pat[JTX_B_MF_MASK] |=> st_r.fcnt == 5'h00;
  endproperty
  a_mf_hit: assert property (p_mf_hit) else $error("reset request ignored");

  property p_sync_pin;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (!st_r.lane[JTX_B_SYNC_SEL] && !sync_n_i) [*2] |=> tx_k_o == 2'b11 && tx_data_o == 16'hBCBC;
  endproperty
  a_sync_pin: assert property (p_sync_pin) else $error("pin sync request not honoured");

  property p_sync_reg;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (st_r.lane[JTX_B_SYNC_SEL] && st_r.lane[JTX_B_SYNC_REG]) [*2] |=> tx_k_o == 2'b11 && tx_data_o == 16'hBCBC;
  endproperty
  a_sync_reg: assert property (p_sync_reg) else $error("register sync request not honoured");

  property p_ila_skip;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      st_r.st == JTX_LS_WAIT && mf_end && !sync_req |=>
        st_r.st == ($past(st_r.link[JTX_B_ILA_SUP]) ? JTX_LS_DATA : JTX_LS_ILA);
  endproperty
  a_ila_skip: assert property (p_ila_skip) else $error("alignment sequence choice wrong");

  property p_ila_start;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      st_r.st == JTX_LS_ILA && st_r.fcnt == 5'h00 |=> tx_k_o[1] && tx_data_o[15:8] == 8'h1C;
  endproperty
  a_ila_start: assert property (p_ila_start) else $error("alignment multiframe start missing");

  property p_flip;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      st_r.st == JTX_LS_DATA && pat_sel == JTX_PAT_NORM && st_r.link[7:1] == 7'h04
        |=> tx_data_o == jtx_rev16($past(sample_i)) && tx_k_o == 2'b00;
  endproperty
  a_flip: assert property (p_flip) else $error("sample bit order not reversed");

  property p_d215;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      st_r.st == JTX_LS_DATA && pat_sel == JTX_PAT_D215 |=> tx_data_o == 16'hB5B5 && tx_k_o == 2'b00;
  endproperty
  a_d215: assert property (p_d215) else $error("D21.5 pattern missing");

  property p_lanes;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      st_r.lane[5:0] == 6'o01 ##1 st_r.lane[5:0] == 6'o42 |-> lane_en_o == 8'hFF ##1 lane_en_o == 8'h01;
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane count table wrong");
endmodule

// ---- verif/jtx_rx_model.sv ----
`timescale 1ns/1ps
module jtx_rx_model (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Link stream from the transmitter
  input  wire logic [15:0] tx_data_i,
  input  wire logic [1:0]  tx_k_i,
  // Bench permission to end code group sync
  input  wire logic        release_i,
  // Sync request, active low
  output logic             sync_n_o
);
  logic [2:0] cgs_cnt_r;

  // Request sync until four K28.5 frames were seen and the bench allows release
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cgs_cnt_r <= 3'h0;
      sync_n_o  <= 1'b0;
    end else begin
      if (tx_data_i == 16'hBCBC && tx_k_i == 2'h3 && cgs_cnt_r != 3'h4) begin
        cgs_cnt_r <= cgs_cnt_r + 3'h1;
      end
      sync_n_o <= release_i && cgs_cnt_r == 3'h4;
    end
  end
endmodule

// ---- verif/jtx_link_ctrl_tb.sv ----
`timescale 1ns/1ps
module jtx_link_ctrl_tb;
  import jtx_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic        rel;
  logic        mfr;
  logic        hrdy;
  logic        hresp;
  logic        sync_n;
  logic        ila;
  logic [1:0]  htrans;
  logic [1:0]  tk;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [15:0] smp;
  logic [15:0] td;
  logic [7:0]  lane;
  int          mismatches;
  int          checked;

  jtx_link_ctrl jtx_link_ctrl_i (.sys_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .sync_n_i(sync_n), .mf_clk_rst_i(mfr),
    .sample_i(smp), .tx_data_o(td), .tx_k_o(tk), .lane_en_o(lane), .ila_active_o(ila));
  jtx_rx_model jtx_rx_model_i (.sys_clk_i(clk), .rst_n_i(rst_n), .tx_data_i(td), .tx_k_i(tk),
    .release_i(rel), .sync_n_o(sync_n));

  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One AHB-Lite single word transfer
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= JTX_HSIZE_WORD;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, {24'h0, d}, x);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Look for a masked k and data pair on the stream within n frames
  task automatic seek(input logic [17:0] v, input logic [17:0] m, input int n);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if ((({tk, td} ^ v) & m) === 18'h0) begin
        hit = 1'b1;
      end
    end
    chk({31'h0, hit}, 32'h1);
  endtask

  // Count frames with the alignment sequence active
  task automatic ila_cnt(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (ila === 1'b1) begin
        c++;
      end
    end
  endtask

  // Reset values, unmapped read, pin sync held
  task automatic t_reset();
    chk({24'h0, lane}, 32'hFF);
    rdchk(32'h00, 32'h00);
    rdchk(32'h04, 32'h01);
    rdchk(32'h08, 32'h00);
    rdchk(32'h18, 32'h08);
    rdchk(32'h40, 32'h00);
    seek({2'h3, 16'hBCBC}, 18'h3FFFF, 8);
  endtask

  // Write ones, reserved bits read zero
  task automatic t_regs();
    wr(32'h00, 8'h9F);
    rdchk(32'h00, 32'h9F);
    wr(32'h08, 8'hFF);
    rdchk(32'h08, 32'hF8);
    wr(32'h18, 8'hFF);
    rdchk(32'h18, 32'h1F);
    wr(32'h00, 8'h00);
    wr(32'h08, 8'h00);
    wr(32'h18, 8'h08);
  endtask

  // Lane count for every mapped decimation and lane code pair, and one unmapped pair
  task automatic t_lanes();
    logic [13:0] tbl [10];
    tbl = '{{6'h04, 8'h0F}, {6'h02, 8'h0F}, {6'h39, 8'h0F}, {6'h31, 8'h0F}, {6'h32, 8'h03},
            {6'h21, 8'h03}, {6'h3A, 8'h03}, {6'h19, 8'h00}, {6'h01, 8'hFF}, {6'h22, 8'h01}};
    foreach (tbl[i]) begin
      wr(32'h04, {2'h0, tbl[i][13:8]});
      for (int j = 0; j < 4 && lane !== tbl[i][7:0]; j++) begin
        @(posedge clk);
      end
      chk({24'h0, lane}, {24'h0, tbl[i][7:0]});
    end
  endtask

  // Sync release with and without the alignment sequence
  task automatic t_ila();
    int c;
    @(posedge clk);
    smp <= 16'h1234;
    rel <= 1'b1;
    ila_cnt(40, c);
    chk({31'h0, c > 0}, 32'h1);
    seek({2'h0, 16'h1234}, 18'h3FFFF, 60);
    wr(32'h00, 8'h01);
    rel <= 1'b0;
    seek({2'h3, 16'hBCBC}, 18'h3FFFF, 8);
    rel <= 1'b1;
    ila_cnt(60, c);
    chk(c, 0);
    seek({2'h0, 16'h1234}, 18'h3FFFF, 4);
    wr(32'h00, 8'h00);
  endtask

  // Bit order reversal of the sample word
  task automatic t_flip();
    logic [15:0] r;
    for (int i = 0; i < 16; i++) begin
      r[i] = smp[15-i];
    end
    wr(32'h00, 8'h08);
    seek({2'h0, r}, 18'h3FFFF, 6);
    wr(32'h00, 8'h00);
  endtask

  // Register sync source against the pin
  task automatic t_sync();
    wr(32'h04, 8'hC1);
    seek({2'h3, 16'hBCBC}, 18'h3FFFF, 6);
    wr(32'h04, 8'h41);
    seek({2'h0, 16'h1234}, 18'h3FFFF, 60);
    rel <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk({16'h0, td}, 32'h1234);
    wr(32'h04, 8'h01);
    seek({2'h3, 16'hBCBC}, 18'h3FFFF, 8);
    rel <= 1'b1;
    seek({2'h0, 16'h1234}, 18'h3FFFF, 60);
  endtask

  // Transport pattern and multiframe length
  task automatic t_tpl(input logic [7:0] ctl, input logic [7:0] top);
    logic [7:0] mx;
    mx = 8'h0;
    wr(32'h18, 8'h02);
    wr(32'h00, ctl);
    repeat (3) @(posedge clk);
    repeat (12) begin
      @(posedge clk);
      #1;
      chk({24'h0, td[7:0]}, {24'h0, ~td[15:8]});
      if (td[15:8] > mx) begin
        mx = td[15:8];
      end
    end
    chk({24'h0, mx}, {24'h0, top});
    wr(32'h00, 8'h00);
    wr(32'h18, 8'h08);
  endtask

  // Multiframe reset request honoured, then masked, on the transport pattern
  task automatic t_mfr();
    logic [7:0] mx;
    mx = 8'h0;
    wr(32'h00, 8'h10);
    mfr <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({16'h0, td}, 32'h00FF);
    wr(32'h08, 8'h08);
    repeat (12) begin
      @(posedge clk);
      #1;
      if (td[15:8] > mx) begin
        mx = td[15:8];
      end
    end
    chk({24'h0, mx}, 32'h04);
    @(posedge clk);
    mfr <= 1'b0;
    wr(32'h08, 8'h00);
    wr(32'h00, 8'h00);
  endtask

  // Link layer test patterns
  task automatic t_pat();
    int c;
    wr(32'h08, 8'h20);
    seek({2'h0, 16'hB5B5}, 18'h0FFFF, 6);
    wr(32'h08, 8'h40);
    seek({2'h3, 16'hBCBC}, 18'h3FFFF, 6);
    wr(32'h08, 8'h60);
    ila_cnt(40, c);
    chk({31'h0, c > 0}, 32'h1);
    wr(32'h08, 8'h00);
    seek({2'h0, 16'h1234}, 18'h3FFFF, 60);
    wr(32'h08, 8'h80);
    seek({2'h0, 16'hBED7}, 18'h0FFFF, 12);
    wr(32'h08, 8'h00);
    seek({2'h0, 16'h1234}, 18'h3FFFF, 60);
  endtask

  // Alignment character insertion on a constant stream
  task automatic t_align();
    wr(32'h00, 8'h04);
    seek({2'h1, 16'h007C}, 18'h100FF, 20);
    wr(32'h00, 8'h02);
    seek({2'h1, 16'h00FC}, 18'h100FF, 20);
    wr(32'h00, 8'h00);
  endtask

  // Report and end the run
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung wait
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end

  // Main sequence
  initial begin
    mismatches = 0;
    checked = 0;
    rst_n = 1'b0;
    {hsel, hwrite, rel, mfr, htrans, hsize, haddr, hwdata} = '0;
    smp = 16'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_regs();
    t_lanes();
    t_ila();
    t_flip();
    t_sync();
    t_tpl(8'h10, 8'h04);
    t_tpl(8'h90, 8'h02);
    t_mfr();
    t_pat();
    t_align();
    wrap_up();
  end
endmodule
